// ==== acl_pkg.sv ====
// Constants, types and helpers shared by the converter control logic.
package acl_pkg;

  localparam int        RES_W         = 12;
  localparam int        SAMPLE_TICKS  = 4;
  localparam int        CONV_TICKS    = 16;

  localparam logic [7:0] OFS_RES_LO   = 8'h00;
  localparam logic [7:0] OFS_RES_HI   = 8'h04;
  localparam logic [7:0] OFS_CTRL     = 8'h08;
  localparam logic [7:0] OFS_CLKSEL   = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

  localparam int        RES_LO_LSB    = 4;
  localparam int        IRQ_DONE_BIT  = 0;

  localparam logic [7:0] CTRL_RST     = 8'h40;
  localparam logic [7:0] CLKSEL_RST   = 8'h00;
  localparam logic [7:0] IRQ_MASK_RST = 8'h00;

  localparam logic [4:0] DIV2_LAST    = 5'h01;
  localparam logic [4:0] DIV8_LAST    = 5'h07;
  localparam logic [4:0] DIV32_LAST   = 5'h1f;

  typedef enum logic [2:0] {
    DIV_BY_2  = 3'b000,
    DIV_BY_8  = 3'b001,
    DIV_BY_32 = 3'b010,
    DIV_UNDEF = 3'b011
  } acl_div_e;

  typedef enum logic [1:0] {
    SAR_IDLE   = 2'b00,
    SAR_SAMPLE = 2'b01,
    SAR_CONV   = 2'b10
  } acl_sar_e;

  typedef struct packed {
    logic       start;
    logic       end_of_conversion_flag_n;
    logic [2:0] pin_config_field;
    logic [2:0] channel_select_field;
  } acl_ctrl_s;

  typedef struct packed {
    logic       converter_power_off;
    logic [3:0] unused;
    logic [2:0] div_code;
  } acl_clksel_s;

  // Code k makes pins 0..k-1 analog; code 7 takes all eight.
  function automatic logic [7:0] pin_mask(input logic [2:0] cfg);
    logic [8:0] m;
    m = (cfg == 3'h7) ? 9'h0ff : ((9'h001 << cfg) - 9'h001);
    return m[7:0];
  endfunction : pin_mask

  function automatic logic [7:0] one_hot(input logic [2:0] sel);
    return 8'h01 << sel;
  endfunction : one_hot

endpackage : acl_pkg

// ==== acl_clkdiv.sv ====
// Conversion clock divider producing a one-cycle enable pulse.
`timescale 1ns/1ps
module acl_clkdiv (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control
  input  wire logic       run,
  input  wire logic [2:0] div_code,
  // Enable pulse at the conversion clock rate
  output logic            tick
);

  logic [4:0] cnt_reg;
  logic [4:0] last;
  logic       valid;

  always_comb begin
    valid = 1'b1;
    case (acl_pkg::acl_div_e'(div_code))
      acl_pkg::DIV_BY_2:  last = acl_pkg::DIV2_LAST;
      acl_pkg::DIV_BY_8:  last = acl_pkg::DIV8_LAST;
      acl_pkg::DIV_BY_32: last = acl_pkg::DIV32_LAST;
      default: begin
        // Undefined codes give no conversion clock at all.
        last  = acl_pkg::DIV32_LAST;
        valid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 5'h00;
      tick    <= 1'b0;
    end else if (!run || !valid) begin
      cnt_reg <= 5'h00;
      tick    <= 1'b0;
    end else begin
      tick    <= (cnt_reg >= last);
      cnt_reg <= (cnt_reg >= last) ? 5'h00 : cnt_reg + 5'h01;
    end
  end

endmodule : acl_clkdiv

// ==== acl_sar.sv ====
// Successive approximation sequencer paced by the conversion clock.
`timescale 1ns/1ps
module acl_sar (
  // Clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // Control
  input  wire logic                   clear,
  input  wire logic                   go,
  input  wire logic                   tick,
  input  wire logic                   cmp_hi,
  // Converter drive and result
  output logic                        sampling,
  output logic [acl_pkg::RES_W-1:0]   dac_code,
  output logic [acl_pkg::RES_W-1:0]   result,
  output logic                        done
);

  acl_pkg::acl_sar_e              state_reg;
  logic [3:0]                     cnt_reg;
  logic [3:0]                     bidx;
  logic [acl_pkg::RES_W-1:0]      trial_next;

  // Keep the trial bit if the input is at or above the trial level.
  always_comb begin
    bidx       = 4'hf - cnt_reg;
    trial_next = dac_code;
    trial_next[bidx] = cmp_hi;
    if (bidx != 4'h0) begin
      trial_next[bidx - 4'h1] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= acl_pkg::SAR_IDLE;
      cnt_reg   <= 4'h0;
      sampling  <= 1'b0;
      dac_code  <= 12'h000;
      result    <= 12'h000;
      done      <= 1'b0;
    end else if (clear) begin
      state_reg <= acl_pkg::SAR_IDLE;
      cnt_reg   <= 4'h0;
      sampling  <= 1'b0;
      dac_code  <= 12'h000;
      done      <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_reg)
        acl_pkg::SAR_IDLE: begin
          if (go) begin
            state_reg <= acl_pkg::SAR_SAMPLE;
            cnt_reg   <= 4'h0;
            sampling  <= 1'b1;
            dac_code  <= 12'h000;
          end
        end
        acl_pkg::SAR_SAMPLE: begin
          if (tick) begin
            cnt_reg <= cnt_reg + 4'h1;
            if (cnt_reg == 4'(acl_pkg::SAMPLE_TICKS - 1)) begin
              state_reg <= acl_pkg::SAR_CONV;
              sampling  <= 1'b0;
              dac_code  <= 12'h800;
            end
          end
        end
        acl_pkg::SAR_CONV: begin
          if (tick) begin
            cnt_reg  <= cnt_reg + 4'h1;
            dac_code <= trial_next;
            if (cnt_reg == 4'(acl_pkg::CONV_TICKS - 1)) begin
              state_reg <= acl_pkg::SAR_IDLE;
              result    <= trial_next;
              done      <= 1'b1;
            end
          end
        end
        default: state_reg <= acl_pkg::SAR_IDLE;
      endcase
    end
  end

endmodule : acl_sar

// ==== acl_top.sv ====
// Converter control block: APB registers, start handshake, power, pins.
`timescale 1ns/1ps
module acl_top (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Interrupt
  output logic             irq,
  // Analog front end
  input  wire logic        cmp_in,
  output logic [7:0]       channel_route,
  output logic [7:0]       analog_pin_en,
  output logic             converter_power_on,
  output logic             converter_reset,
  output logic             sample_hold,
  output logic [11:0]      dac_code
);

  acl_pkg::acl_ctrl_s   ctrl_reg;
  acl_pkg::acl_clksel_s clksel_reg;
  logic [7:0]           res_lo_reg;
  logic [7:0]           res_hi_reg;
  logic [7:0]           irq_stat_reg;
  logic [7:0]           irq_mask_reg;
  logic [7:0]           stat_seen_reg;
  logic                 cmp_meta_reg;
  logic                 cmp_sync_reg;
  logic                 go_reg;

  logic                 access;
  logic                 commit;
  logic                 first_access;
  logic                 mapped;
  logic                 wr_ctrl;
  logic                 wr_clksel;
  logic                 wr_mask;
  logic                 rd_stat;
  logic                 start_rise;
  logic                 start_fall;
  logic                 powered;
  logic                 tick;
  logic                 done;
  logic                 sampling;
  logic [11:0]          sar_dac;
  logic [11:0]          sar_result;
  logic [7:0]           rd_mux;

  // Bus decode.
  assign access = psel & penable;
  assign commit = access & pready;

  always_comb begin
    mapped = 1'b1;
    case (paddr)
      acl_pkg::OFS_RES_LO:   rd_mux = res_lo_reg;
      acl_pkg::OFS_RES_HI:   rd_mux = res_hi_reg;
      acl_pkg::OFS_CTRL:     rd_mux = ctrl_reg;
      acl_pkg::OFS_CLKSEL:   rd_mux = clksel_reg;
      acl_pkg::OFS_IRQ_STAT: rd_mux = irq_stat_reg;
      acl_pkg::OFS_IRQ_MASK: rd_mux = irq_mask_reg;
      default: begin
        rd_mux = 8'h00;
        mapped = 1'b0;
      end
    endcase
  end

  assign wr_ctrl   = commit & pwrite & (paddr == acl_pkg::OFS_CTRL);
  assign wr_clksel = commit & pwrite & (paddr == acl_pkg::OFS_CLKSEL);
  assign wr_mask   = commit & pwrite & (paddr == acl_pkg::OFS_IRQ_MASK);
  assign rd_stat   = commit & !pwrite & (paddr == acl_pkg::OFS_IRQ_STAT);

  // Power follows the pin field and the power-off bit alike.
  assign powered = (ctrl_reg.pin_config_field != 3'h0) &
                   !clksel_reg.converter_power_off;

  // Start edges are seen on the written value against the held one.
  assign start_rise = wr_ctrl & pwdata[7] & !ctrl_reg.start;
  assign start_fall = wr_ctrl & !pwdata[7] & ctrl_reg.start;

  // One wait state lets read data come straight from a flop.
  assign first_access = access & !pready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= first_access;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (first_access) begin
      prdata <= {24'h00_0000, rd_mux};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (first_access) begin
      pslverr <= !mapped;
    end else if (!access) begin
      pslverr <= 1'b0;
    end
  end

  // The status snapshot marks which bits the pending read will clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_seen_reg <= 8'h00;
    end else if (first_access) begin
      stat_seen_reg <= irq_stat_reg;
    end
  end

  // Software fields of the control register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg.start                <= acl_pkg::CTRL_RST[7];
      ctrl_reg.pin_config_field     <= acl_pkg::CTRL_RST[5:3];
      ctrl_reg.channel_select_field <= acl_pkg::CTRL_RST[2:0];
    end else if (wr_ctrl) begin
      ctrl_reg.start                <= pwdata[7];
      ctrl_reg.pin_config_field     <= pwdata[5:3];
      ctrl_reg.channel_select_field <= pwdata[2:0];
    end
  end

  // Bits 6..3 of the clock select register always read zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clksel_reg <= acl_pkg::CLKSEL_RST;
    end else if (wr_clksel) begin
      clksel_reg.converter_power_off <= pwdata[7];
      clksel_reg.unused              <= 4'h0;
      clksel_reg.div_code            <= pwdata[2:0];
    end
  end

  // Mask bit 0 gates the conversion-done interrupt.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_reg <= acl_pkg::IRQ_MASK_RST;
    end else if (wr_mask) begin
      irq_mask_reg <= pwdata[7:0];
    end
  end

  // End-of-conversion flag: a start rise while powered forces it high;
  // a finished conversion drops it. A powered-down start does nothing.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg.end_of_conversion_flag_n <= acl_pkg::CTRL_RST[6];
    end else if (start_rise && powered) begin
      ctrl_reg.end_of_conversion_flag_n <= 1'b1;
    end else if (done) begin
      ctrl_reg.end_of_conversion_flag_n <= 1'b0;
    end
  end

  // A conversion is launched by the falling half of the start pulse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      go_reg <= 1'b0;
    end else begin
      go_reg <= start_fall & powered;
    end
  end

  // Comparator pin is asynchronous to pclk. The answer to a new trial
  // code arrives three cycles late, so the fastest clock code leaves
  // too little time per bit at this system clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_meta_reg <= 1'b0;
      cmp_sync_reg <= 1'b0;
    end else begin
      cmp_meta_reg <= cmp_in;
      cmp_sync_reg <= cmp_meta_reg;
    end
  end

  acl_clkdiv u_clkdiv (
    .pclk     (pclk),
    .presetn  (presetn),
    .run      (powered),
    .div_code (clksel_reg.div_code),
    .tick     (tick)
  );

  // Held in reset while start is high or power is off.
  acl_sar u_sar (
    .pclk     (pclk),
    .presetn  (presetn),
    .clear    (ctrl_reg.start | !powered),
    .go       (go_reg),
    .tick     (tick),
    .cmp_hi   (cmp_sync_reg),
    .sampling (sampling),
    .dac_code (sar_dac),
    .result   (sar_result),
    .done     (done)
  );

  // Result bytes change only when a conversion completes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_hi_reg <= 8'h00;
      res_lo_reg <= 8'h00;
    end else if (done) begin
      res_hi_reg <= sar_result[11:4];
      res_lo_reg <= {sar_result[3:0], 4'h0};
    end
  end

  // Sticky status, cleared by a read; a new event wins over the clear.
  // Only bits that the read returned are cleared, so none is lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= 8'h00;
    end else begin
      irq_stat_reg <= (rd_stat ? (irq_stat_reg & ~stat_seen_reg)
                               : irq_stat_reg)
                      | {7'h00, done};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // Analog pin and converter drive, all from flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_route <= 8'h00;
    end else if (powered) begin
      channel_route <=
          acl_pkg::one_hot(ctrl_reg.channel_select_field);
    end else begin
      channel_route <= 8'h00;
    end
  end

  // Enabled pins override port direction and drop the pull-up.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_pin_en <= 8'h00;
    end else begin
      analog_pin_en <=
          acl_pkg::pin_mask(ctrl_reg.pin_config_field);
    end
  end

  // Power reaches the front end one cycle after the register write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_power_on <= 1'b0;
    end else begin
      converter_power_on <= powered;
    end
  end

  // Reset follows start only while powered, so a cut supply wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_reset <= 1'b0;
    end else begin
      converter_reset <= ctrl_reg.start & powered;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_hold <= 1'b0;
    end else begin
      sample_hold <= sampling;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_code <= 12'h000;
    end else begin
      dac_code <= sar_dac;
    end
  end

endmodule : acl_top

// ==== acl_top_assertions.sv ====
// Port-level assertions for the converter control block.
`timescale 1ns/1ps
module acl_top_checker (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Interrupt and converter drive
  input wire logic        irq,
  input wire logic [7:0]  channel_route,
  input wire logic        converter_power_on,
  input wire logic        converter_reset,
  input wire logic        sample_hold
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    !pready ##1 pready;
  endsequence
  sequence s_rd;
    psel && penable && pready && !pwrite;
  endsequence

  property p_ready;
    s_setup |=> s_answer;
  endproperty
  property p_err;
    psel && penable && pready && paddr > 8'h14
      |-> pslverr && (pwrite || prdata == 32'h0);
  endproperty
  property p_upper;
    s_rd |-> prdata[31:8] == 24'h0;
  endproperty
  property p_lo;
    s_rd ##0 paddr == acl_pkg::OFS_RES_LO |-> prdata[3:0] == 4'h0;
  endproperty
  property p_flag;
    s_rd ##0 (paddr == acl_pkg::OFS_CTRL && converter_reset
      && $past(converter_reset)) |-> prdata[7:6] == 2'b11;
  endproperty
  property p_off;
    !converter_power_on && !$past(converter_power_on)
      |-> channel_route == 8'h00 && !converter_reset && !sample_hold;
  endproperty
  property p_rstpw;
    converter_reset |-> converter_power_on || $past(converter_power_on);
  endproperty
  property p_route;
    channel_route != 8'h00 |-> $onehot(channel_route);
  endproperty
  property p_hold;
    converter_reset && $past(converter_reset) |-> !sample_hold;
  endproperty
  // Status clears only through a bus access, so irq never drops alone.
  property p_irqfall;
    $fell(irq) |-> $past(psel) || $past(psel, 2) || $past(psel, 3);
  endproperty

  a_ready: assert property (p_ready) else $error("pready timing wrong");
  a_err: assert property (p_err) else $error("unmapped access wrong");
  a_upper: assert property (p_upper)
    else $error("read data above byte");
  a_lo: assert property (p_lo)
    else $error("low result nibble set");
  a_flag: assert property (p_flag)
    else $error("flag low in reset");
  a_off: assert property (p_off)
    else $error("active while unpowered");
  a_rstpw: assert property (p_rstpw)
    else $error("reset while unpowered");
  a_route: assert property (p_route)
    else $error("route not one-hot");
  a_hold: assert property (p_hold)
    else $error("sampling in reset");
  a_irqfall: assert property (p_irqfall)
    else $error("irq fell alone");
endmodule : acl_top_checker

bind acl_top acl_top_checker u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .irq, .channel_route,
  .converter_power_on, .converter_reset, .sample_hold);

// ==== acl_ana_model.sv ====
// Comparator model of the analog inputs seen by the converter.
`timescale 1ns/1ps
module acl_ana_model (
  // Clock
  input wire logic        pclk,
  // Levels and converter drive
  input wire logic [95:0] levels,
  input wire logic [7:0]  channel_route,
  input wire logic        converter_power_on,
  input wire logic [11:0] dac_code,
  // Comparator
  output logic            cmp_in
);
  logic [11:0] lvl;
  logic        junk = 1'b0;
  always_comb begin
    lvl = 12'h000;
    for (int i = 0; i < 8; i++)
      if (channel_route[i]) lvl = levels[i*12 +: 12];
  end
  // An unpowered comparator gives no steady answer, so it toggles.
  always @(posedge pclk) junk <= ~junk;
  assign cmp_in = converter_power_on ? (lvl >= dac_code) : junk;
endmodule : acl_ana_model

// ==== acl_top_tb.sv ====
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
module acl_top_tb;
  localparam logic [32:0] ALL = 33'h1ffffffff;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, irq, cmp_in;
  logic        converter_power_on, converter_reset, sample_hold;
  logic [7:0]  paddr, channel_route, analog_pin_en;
  logic [31:0] pwdata, prdata;
  logic [11:0] dac_code;
  logic [95:0] levels;
  logic [32:0] exp_q[$], care_q[$];
  int          mismatches = 0;
  int          num_checks = 0;

  always #2.5 pclk = ~pclk;

  acl_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .irq, .cmp_in, .channel_route,
    .analog_pin_en, .converter_power_on, .converter_reset, .sample_hold,
    .dac_code);
  acl_ana_model u_ana (.pclk, .levels, .channel_route, .converter_power_on,
    .dac_code, .cmp_in);

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude

  task automatic check(input logic [32:0] act, exp, care);
    num_checks++;
    if (((act ^ exp) & care) !== 33'h0) begin
      mismatches++;
      $display("MISMATCH t=%0t act=%h exp=%h", $time, act, exp);
    end
  endtask : check

  task automatic chk8(input logic [7:0] act, exp);
    check({25'h0, act}, {25'h0, exp}, ALL);
  endtask : chk8

  // Registered outputs lag the write by a stage, so look a few cycles on.
  task automatic settle();
    repeat (3) @(negedge pclk);
  endtask : settle

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [32:0] e, c);
    logic [31:0] q;
    exp_q.push_back(e);
    care_q.push_back(c);
    apb(1'b0, a, 32'h0, q);
  endtask : rd

  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
      check({pslverr, prdata}, exp_q.pop_front(), care_q.pop_front());

  task automatic conv(input logic [2:0] ch, code, input logic ie);
    logic [31:0] q;
    int          n;
    int          dv;
    dv = code == 3'h0 ? 2 : (code == 3'h1 ? 8 : 32);
    n = 0;
    wr(acl_pkg::OFS_CLKSEL, {29'h0, code});
    wr(acl_pkg::OFS_IRQ_MASK, {31'h0, ie});
    wr(acl_pkg::OFS_CTRL, {24'h0, 2'b10, 3'h7, ch});
    rd(acl_pkg::OFS_CTRL, {25'h0, 2'b11, 3'h7, ch}, ALL);
    settle();
    chk8({7'h0, converter_reset}, 8'h01);
    chk8(channel_route, 8'h01 << ch);
    wr(acl_pkg::OFS_CTRL, {26'h0, 3'h7, ch});
    if (ie) begin
      while (irq !== 1'b1) begin
        @(posedge pclk);
        n++;
      end
      check({32'h0, n >= 15 * dv + 2 && n <= 17 * dv + 8}, 33'h1, ALL);
    end else begin
      do apb(1'b0, acl_pkg::OFS_CTRL, 32'h0, q); while (q[6] !== 1'b0);
      settle();
      chk8({7'h0, irq}, 8'h00);
    end
    rd(acl_pkg::OFS_IRQ_STAT, 33'h1, ALL);
    rd(acl_pkg::OFS_IRQ_STAT, 33'h0, ALL);
    rd(acl_pkg::OFS_CTRL, {27'h0, 3'h7, ch}, ALL);
    if (code != 3'h0) begin
      rd(acl_pkg::OFS_RES_HI, {25'h0, levels[ch*12+4 +: 8]}, ALL);
      rd(acl_pkg::OFS_RES_LO, {25'h0, levels[ch*12 +: 4], 4'h0}, ALL);
    end
  endtask : conv

  initial begin
    logic [15:0] r;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    r = 16'h0034;
    for (int i = 0; i < 8; i++) begin
      r = lfsr(r);
      levels[i*12 +: 12] = r[11:0];
    end
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(acl_pkg::OFS_CTRL, 33'h40, ALL);
    rd(acl_pkg::OFS_CLKSEL, 33'h0, ALL);
    rd(acl_pkg::OFS_IRQ_MASK, 33'h0, ALL);
    rd(8'h18, 33'h100000000, ALL);
    for (int k = 0; k < 8; k++) begin
      wr(acl_pkg::OFS_CTRL, {26'h0, k[2:0], 3'h0});
      settle();
      chk8(analog_pin_en, k == 7 ? 8'hff : 8'((1 << k) - 1));
      chk8({7'h0, converter_power_on}, {7'h0, k != 0});
    end
    wr(acl_pkg::OFS_CLKSEL, 32'h80);
    settle();
    chk8({7'h0, converter_power_on}, 8'h00);
    for (int c = 0; c < 8; c++)
      conv(c[2:0], 3'(c % 3), c[0]);
    wr(acl_pkg::OFS_CLKSEL, 32'h81);
    wr(acl_pkg::OFS_CTRL, 32'hbf);
    rd(acl_pkg::OFS_CTRL, 33'h0, 33'h40);
    wr(acl_pkg::OFS_CTRL, 32'h3f);
    repeat (300) @(posedge pclk);
    settle();
    chk8({7'h0, irq}, 8'h00);
    rd(acl_pkg::OFS_RES_HI, {25'h0, levels[95:88]}, ALL);
    wr(acl_pkg::OFS_CLKSEL, 32'h03);
    wr(acl_pkg::OFS_CTRL, 32'hbf);
    wr(acl_pkg::OFS_CTRL, 32'h3f);
    repeat (600) @(posedge pclk);
    rd(acl_pkg::OFS_CTRL, 33'h7f, ALL);
    rd(acl_pkg::OFS_RES_HI, {25'h0, levels[95:88]}, ALL);
    // Let the monitor take the last read before the verdict.
    @(posedge pclk);
    conclude();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    conclude();
  end
endmodule : acl_top_tb
